/* shared/smb_pkg.sv */
package smb_pkg;

   // ----------------------------------------
   // Widths and depths
   // ----------------------------------------
   localparam int ADDR_W     = 12;
   localparam int COL_W      = 9;
   localparam int BEAT_W     = 10;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_W     = COL_W + 2;

   // ----------------------------------------
   // Base mode register fields
   // ----------------------------------------
   localparam int BL_LSB     = 0;
   localparam int BL_W       = 3;
   localparam int ORDER_BIT  = 3;
   localparam int LAT_LSB    = 4;
   localparam int LAT_W      = 3;
   localparam int OPM_LSB    = 7;
   localparam int OPM_W      = 2;
   localparam int WBM_BIT    = 9;
   localparam int RSV_LSB    = 10;
   localparam int RSV_W      = 2;

   // ----------------------------------------
   // Extended mode register fields
   // ----------------------------------------
   localparam int TEMP_LSB   = 3;
   localparam int TEMP_W     = 2;
   localparam int XRSV_LSB   = 5;
   localparam int XRSV_W     = 7;

   // ----------------------------------------
   // Codes
   // ----------------------------------------
   localparam logic [2:0] BL_CODE_1    = 3'h0;
   localparam logic [2:0] BL_CODE_2    = 3'h1;
   localparam logic [2:0] BL_CODE_4    = 3'h2;
   localparam logic [2:0] BL_CODE_8    = 3'h3;
   localparam logic [2:0] BL_CODE_PAGE = 3'h7;
   localparam logic [2:0] LAT_CODE_1   = 3'h1;
   localparam logic [2:0] LAT_CODE_2   = 3'h2;
   localparam logic [2:0] LAT_CODE_3   = 3'h3;
   localparam logic [1:0] LAT_ONE      = 2'h1;
   localparam logic [1:0] LAT_TWO      = 2'h2;
   localparam logic [1:0] LAT_THREE    = 2'h3;
   localparam logic [1:0] SEL_BASE     = 2'h0;
   localparam logic [1:0] SEL_EXT      = 2'h2;

   // ----------------------------------------
   // Beat counts and reset values
   // ----------------------------------------
   localparam logic [9:0]  BEATS_1    = 10'h001;
   localparam logic [9:0]  BEATS_2    = 10'h002;
   localparam logic [9:0]  BEATS_4    = 10'h004;
   localparam logic [9:0]  BEATS_8    = 10'h008;
   localparam logic [9:0]  PAGE_X16   = 10'h200;
   localparam logic [9:0]  PAGE_X32   = 10'h100;
   localparam logic [11:0] BASE_RESET = 12'h020;
   localparam logic [11:0] EXT_RESET  = 12'h000;

   typedef enum logic {
      SEQ_IDLE = 1'b0,
      SEQ_RUN  = 1'b1
   } smb_seq_t;

endpackage

/* rtl/smb_sequencer.sv */
`timescale 1ns/10ps

// ----------------------------------------
// Column FIFO with registered output stage
// ----------------------------------------
module smb_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             nrst_in,
   input  wire logic             ce_in,
   // Fill side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   always_comb begin
      in_ready_out = (count != (AW + 1)'(DEPTH));
      push         = ce_in && in_valid_in && in_ready_out;
      pop          = ce_in && (count != '0) && (!out_valid_out || out_ready_in);
   end

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= AW'(wr_ptr + 1'b1);
         end
         if (pop) begin
            rd_ptr <= AW'(rd_ptr + 1'b1);
         end
         if (push && !pop) begin
            count <= (AW + 1)'(count + 1'b1);
         end else if (pop && !push) begin
            count <= (AW + 1)'(count - 1'b1);
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         out_valid_out <= 1'b0;
         out_data_out  <= '0;
      end else if (ce_in) begin
         if (pop) begin
            out_valid_out <= 1'b1;
            out_data_out  <= mem[rd_ptr];
         end else if (out_ready_in) begin
            out_valid_out <= 1'b0;
         end
      end
   end

   fifo_full_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (count == (AW + 1)'(DEPTH)) |-> !in_ready_out)
      else $error("fifo accepts data while full");
endmodule

module smb_sequencer (
   // Clock and reset
   input  wire logic                          clk_in,
   input  wire logic                          nrst_in,
   input  wire logic                          ce_in,
   // Commands
   input  wire logic                          mode_load_in,
   input  wire logic                          read_cmd_in,
   input  wire logic                          write_cmd_in,
   input  wire logic [1:0]                    bank_sel_in,
   input  wire logic [smb_pkg::ADDR_W-1:0]    addr_in,
   input  wire logic                          wide_part_in,
   // Column stream
   output logic      [smb_pkg::COL_W-1:0]     col_out,
   output logic                               col_write_out,
   output logic                               col_last_out,
   output logic                               col_valid_out,
   input  wire logic                          col_ready_in,
   // Read data timing
   output logic                               dq_oe_n_out,
   output logic                               rd_data_valid_out,
   // Status
   output logic                               burst_busy_out,
   output logic      [smb_pkg::TEMP_W-1:0]    temp_range_out,
   output logic                               mode_reserved_out,
   output logic                               ext_reserved_out
);
   import smb_pkg::*;

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   function automatic logic [BEAT_W-1:0] burst_beats(input logic [2:0] code,
                                                     input logic       wide);
      unique case (code)
         BL_CODE_1:    return BEATS_1;
         BL_CODE_2:    return BEATS_2;
         BL_CODE_4:    return BEATS_4;
         BL_CODE_8:    return BEATS_8;
         BL_CODE_PAGE: return wide ? PAGE_X32 : PAGE_X16;
         // Reserved lengths fall back to a single beat
         default:      return BEATS_1;
      endcase
   endfunction

   function automatic logic [1:0] lat_clocks(input logic [2:0] code);
      unique case (code)
         LAT_CODE_1: return LAT_ONE;
         LAT_CODE_2: return LAT_TWO;
         LAT_CODE_3: return LAT_THREE;
         // Reserved latencies run as the slowest legal one
         default:    return LAT_THREE;
      endcase
   endfunction

   function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0]  start,
                                                 input logic [BEAT_W-1:0] k,
                                                 input logic [BEAT_W-1:0] beats,
                                                 input logic              ilv);
      logic [COL_W-1:0] mask;
      logic [COL_W-1:0] offs;
      mask = COL_W'(beats - BEATS_1);
      offs = ilv ? (start ^ k[COL_W-1:0]) : COL_W'(start + k[COL_W-1:0]);
      return (start & ~mask) | (offs & mask);
   endfunction

   // ----------------------------------------
   // Mode registers
   // ----------------------------------------
   logic [ADDR_W-1:0] base_mode_config;
   logic [ADDR_W-1:0] extended_mode_config;
   logic              take_load;
   logic              take_read;
   logic              take_write;
   logic [BEAT_W-1:0] cur_beats;
   logic              ilv_now;
   logic [1:0]        lat_now;
   logic              write_burst_mode_bit;
   logic [COL_W-1:0]  cmd_col;

   always_comb begin
      take_load  = ce_in && mode_load_in;
      take_read  = ce_in && !mode_load_in && read_cmd_in;
      take_write = ce_in && !mode_load_in && !read_cmd_in && write_cmd_in;
      cur_beats  = burst_beats(base_mode_config[BL_LSB +: BL_W], wide_part_in);
      // Full page forces sequential; single beat has no order at all
      ilv_now = base_mode_config[ORDER_BIT] && (cur_beats <= BEATS_8);
      lat_now = lat_clocks(base_mode_config[LAT_LSB +: LAT_W]);
      write_burst_mode_bit = base_mode_config[WBM_BIT];
      cmd_col = wide_part_in ? {1'b0, addr_in[COL_W-2:0]} : addr_in[COL_W-1:0];
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         base_mode_config <= BASE_RESET;
      end else if (take_load && bank_sel_in == SEL_BASE) begin
         base_mode_config <= addr_in;
      end
   end

   // Holds its value across every other command
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         extended_mode_config <= EXT_RESET;
      end else if (take_load && bank_sel_in == SEL_EXT) begin
         extended_mode_config <= addr_in;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         temp_range_out    <= '0;
         mode_reserved_out <= 1'b0;
         ext_reserved_out  <= 1'b0;
      end else if (ce_in) begin
         temp_range_out    <= extended_mode_config[TEMP_LSB +: TEMP_W];
         mode_reserved_out <= (base_mode_config[OPM_LSB +: OPM_W] != '0)
                           || (base_mode_config[RSV_LSB +: RSV_W] != '0)
                           || (base_mode_config[LAT_LSB +: LAT_W] > LAT_CODE_3)
                           || (base_mode_config[LAT_LSB +: LAT_W] < LAT_CODE_1);
         ext_reserved_out  <= extended_mode_config[XRSV_LSB +: XRSV_W] != '0;
      end
   end

   // ----------------------------------------
   // Column sequencer
   // ----------------------------------------
   smb_seq_t          seq_state;
   logic [COL_W-1:0]  start_col;
   logic [BEAT_W-1:0] beat_idx;
   logic [BEAT_W-1:0] beats_q;
   logic              ilv_q;
   logic              is_write_q;
   logic              push_valid;
   logic              push_ready;
   logic              push_last;
   logic [COL_W-1:0]  push_col;

   always_comb begin
      push_valid = (seq_state == SEQ_RUN);
      push_last  = (beat_idx == BEAT_W'(beats_q - BEATS_1));
      push_col   = beat_col(start_col, beat_idx, beats_q, ilv_q);
   end

   // Mode is sampled at each command, so a reload affects only later bursts
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         seq_state  <= SEQ_IDLE;
         start_col  <= '0;
         beat_idx   <= '0;
         beats_q    <= BEATS_1;
         ilv_q      <= 1'b0;
         is_write_q <= 1'b0;
      end else if (ce_in) begin
         if (take_read || take_write) begin
            seq_state  <= SEQ_RUN;
            start_col  <= cmd_col;
            beat_idx   <= '0;
            beats_q    <= (take_write && write_burst_mode_bit) ? BEATS_1 : cur_beats;
            ilv_q      <= ilv_now;
            is_write_q <= take_write;
         end else if (push_valid && push_ready) begin
            beat_idx <= BEAT_W'(beat_idx + BEATS_1);
            if (push_last) begin
               seq_state <= SEQ_IDLE;
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         burst_busy_out <= 1'b0;
      end else if (ce_in) begin
         burst_busy_out <= (take_read || take_write)
                        || (push_valid && !(push_ready && push_last));
      end
   end

   // Back-pressure from the drain stalls the sequencer, not the data pins
   smb_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .nrst_in       (nrst_in),
      .ce_in         (ce_in),
      .in_valid_in   (push_valid),
      .in_ready_out  (push_ready),
      .in_data_in    ({is_write_q, push_last, push_col}),
      .out_valid_out (col_valid_out),
      .out_ready_in  (col_ready_in),
      .out_data_out  ({col_write_out, col_last_out, col_out})
   );

   // ----------------------------------------
   // Read latency and data window
   // ----------------------------------------
   logic [1:0]        lat_cnt;
   logic [BEAT_W-1:0] rd_left;
   logic [BEAT_W-1:0] rd_beats_q;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lat_cnt           <= '0;
         rd_left           <= '0;
         rd_beats_q        <= BEATS_1;
         dq_oe_n_out       <= 1'b1;
         rd_data_valid_out <= 1'b0;
      end else if (ce_in) begin
         if (take_read) begin
            rd_beats_q        <= cur_beats;
            rd_data_valid_out <= 1'b0;
            if (lat_now == LAT_ONE) begin
               dq_oe_n_out <= 1'b0;
               rd_left     <= cur_beats;
               lat_cnt     <= '0;
            end else begin
               dq_oe_n_out <= 1'b1;
               rd_left     <= '0;
               lat_cnt     <= 2'(lat_now - LAT_ONE);
            end
         end else if (lat_cnt == LAT_ONE) begin
            dq_oe_n_out       <= 1'b0;
            rd_left           <= rd_beats_q;
            lat_cnt           <= '0;
            rd_data_valid_out <= 1'b0;
         end else if (lat_cnt != '0) begin
            lat_cnt           <= 2'(lat_cnt - LAT_ONE);
            rd_data_valid_out <= 1'b0;
         end else if (rd_left != '0) begin
            rd_data_valid_out <= 1'b1;
            rd_left           <= BEAT_W'(rd_left - BEATS_1);
         end else begin
            rd_data_valid_out <= 1'b0;
            dq_oe_n_out       <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   lat_one_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (take_read && lat_now == LAT_ONE) |=> !dq_oe_n_out)
      else $error("latency one read not driving at first edge");

   lat_two_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (take_read && lat_now == LAT_TWO ##1 ce_in && !read_cmd_in && !mode_load_in)
      |=> !dq_oe_n_out)
      else $error("latency two read not driving at edge n+1");

   lat_three_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (take_read && lat_now == LAT_THREE) |=> dq_oe_n_out)
      else $error("latency three read drives too early");

   data_valid_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      ($fell(dq_oe_n_out) && ce_in && !take_read) |=> rd_data_valid_out)
      else $error("read data not valid one edge after drive start");

   ext_load_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (take_load && bank_sel_in == SEL_EXT ##1 ce_in)
      |=> temp_range_out == $past(addr_in[TEMP_LSB +: TEMP_W], 2))
      else $error("extended register load not seen on temperature range");

   base_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (take_load && bank_sel_in != SEL_BASE)
      |=> base_mode_config == $past(base_mode_config))
      else $error("base register changed on foreign bank select");

   block_wrap_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      push_valid |-> ((push_col & ~COL_W'(beats_q - BEATS_1))
                   == (start_col & ~COL_W'(beats_q - BEATS_1))))
      else $error("burst column left its aligned block");

   order_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (push_valid && ilv_q && beats_q == BEATS_8)
      |-> push_col[2:0] == (start_col[2:0] ^ beat_idx[2:0]))
      else $error("interleaved column order wrong");

   single_wr_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (take_write && write_burst_mode_bit) |=> (beats_q == BEATS_1 && push_valid))
      else $error("write burst mode did not force a single beat");

   page_seq_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (push_valid && beats_q > BEATS_8) |-> !ilv_q)
      else $error("full page burst not sequential");
endmodule

/* tb/smb_col_sink.sv */
`timescale 1ns/10ps

// ----------------------------------------
// Column stream sink
// ----------------------------------------
module smb_col_sink (
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   input  wire logic       stall_in,
   input  wire logic       clr_in,
   input  wire logic [8:0] col_in,
   input  wire logic       wr_in,
   input  wire logic       last_in,
   input  wire logic       valid_in,
   output logic            ready_out
);
   logic [8:0] cap [0:511];
   int         n_cap;
   int         n_last;
   logic       wr_seen;

   // Ready only moves just after an edge
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         ready_out <= 1'b0;
      else
         ready_out <= !stall_in;
   end

   always_ff @(posedge clk_in) begin
      if (clr_in) begin
         n_cap <= 0;
         n_last <= 0;
         wr_seen <= 1'b0;
      end else if (valid_in && ready_out) begin
         cap[n_cap[8:0]] <= col_in;
         n_cap <= n_cap + 1;
         n_last <= n_last + int'(last_in);
         wr_seen <= wr_in;
      end
   end
endmodule

/* tb/smb_sequencer_tb.sv */
`timescale 1ns/10ps

module smb_sequencer_tb;
   import smb_pkg::*;

   logic        clk_in;
   logic        nrst_in;
   logic        ml;
   logic        rd;
   logic        wr;
   logic [1:0]  bank;
   logic [11:0] addr;
   logic        wide;
   logic        stall;
   logic        clr;
   logic        ready;
   logic [8:0]  col;
   logic        col_wr;
   logic        col_last;
   logic        col_valid;
   logic        oe_n;
   logic        rdv;
   logic        busy;
   logic [1:0]  temp;
   logic        mres;
   logic        xres;
   int          n_mismatch;
   int          checked;

   smb_sequencer i_dut (
      .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1),
      .mode_load_in(ml), .read_cmd_in(rd), .write_cmd_in(wr),
      .bank_sel_in(bank), .addr_in(addr), .wide_part_in(wide),
      .col_out(col), .col_write_out(col_wr), .col_last_out(col_last),
      .col_valid_out(col_valid), .col_ready_in(ready),
      .dq_oe_n_out(oe_n), .rd_data_valid_out(rdv), .burst_busy_out(busy),
      .temp_range_out(temp), .mode_reserved_out(mres), .ext_reserved_out(xres)
   );

   smb_col_sink i_sink (
      .clk_in(clk_in), .nrst_in(nrst_in), .stall_in(stall), .clr_in(clr),
      .col_in(col), .wr_in(col_wr), .last_in(col_last), .valid_in(col_valid),
      .ready_out(ready)
   );

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic cmd(input logic l, input logic r, input logic w,
                      input logic [1:0] b, input logic [11:0] a);
      @(posedge clk_in);
      ml <= l;
      rd <= r;
      wr <= w;
      bank <= b;
      addr <= a;
      @(posedge clk_in);
      ml <= 1'b0;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic settle();
      repeat (2) @(posedge clk_in);
      #1;
   endtask

   task automatic sclr();
      @(posedge clk_in);
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
   endtask

   // Bounded wait; the sink must have taken every beat
   task automatic drain();
      int i;
      i = 0;
      settle();
      while ((busy !== 1'b0 || col_valid !== 1'b0) && i < 2000) begin
         @(posedge clk_in);
         #1;
         i++;
      end
      repeat (2) @(posedge clk_in);
      chk("drain", 16'(i < 2000), 16'h1);
   endtask

   function automatic logic [8:0] exp_col(logic [8:0] s, int n, int k, logic ilv, int pg);
      logic [8:0] m;
      m = 9'(n - 1);
      if (n == pg)
         return 9'((int'(s) + k) % pg);
      if (ilv)
         return (s & ~m) | ((s ^ 9'(k)) & m);
      return (s & ~m) | ((s + 9'(k)) & m);
   endfunction

   task automatic check_cap(string what, logic [8:0] s, int n, logic ilv, int pg);
      chk({what, " beats"}, 16'(i_sink.n_cap), 16'(n));
      chk({what, " last"}, 16'(i_sink.n_last), 16'h1);
      for (int k = 0; k < n; k++)
         chk(what, 16'(i_sink.cap[k]), 16'(exp_col(s, n, k, ilv, pg)));
   endtask

   initial begin
      #200000;
      n_mismatch++;
      wrap_up();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      logic [8:0] st;
      logic       wbm;
      logic       w;
      int         n;
      int         fo;
      int         fv;
      int         nv;
      n_mismatch = 0;
      checked = 0;
      nrst_in = 1'b0;
      {ml, rd, wr, wide, stall, clr} = 6'h00;
      bank = 2'h0;
      addr = 12'h000;
      repeat (6) @(posedge clk_in);
      nrst_in <= 1'b1;
      #1;
      chk("reset oe_n", 16'(oe_n), 16'h1);
      chk("reset flags", 16'({rdv, col_valid, busy, temp, mres, xres}), 16'h0);
      $display("test reset done");

      // Lengths 1 to 8, each type, direction and write mode, from start columns 006 and 1FD
      for (int op = 0; op < 4; op++)
         for (int c = 0; c < 4; c++)
            for (int t = 0; t < 2; t++)
               for (int s = 0; s < 2; s++) begin
                  st = s ? 9'h1FD : 9'h006;
                  wbm = op >= 2;
                  w = op == 1 || op == 2;
                  n = (op == 2) ? 1 : (1 << c);
                  cmd(1'b1, 1'b0, 1'b0, SEL_BASE, {2'h0, wbm, 5'h02, 1'(t), 3'(c)});
                  sclr();
                  cmd(1'b0, !w, w, SEL_BASE, {3'h0, st});
                  drain();
                  check_cap("burst col", st, n, 1'(t), 512);
                  chk("burst write", 16'(i_sink.wr_seen), 16'(w));
               end
      $display("test burst order done");

      for (int m = 1; m <= 3; m++) begin
         cmd(1'b1, 1'b0, 1'b0, SEL_BASE, 12'h202 | 12'(m << 4));
         cmd(1'b0, 1'b1, 1'b0, SEL_BASE, 12'h000);
         fo = -1;
         fv = -1;
         nv = 0;
         for (int i = 0; i < 10; i++) begin
            #1;
            if (oe_n === 1'b0 && fo < 0)
               fo = i;
            if (rdv === 1'b1) begin
               if (fv < 0)
                  fv = i;
               nv++;
            end
            @(posedge clk_in);
         end
         #1;
         chk("oe start", 16'(fo), 16'(m - 1));
         chk("valid start", 16'(fv), 16'(m));
         chk("valid beats", 16'(nv), 16'h4);
         chk("oe released", 16'(oe_n), 16'h1);
      end
      drain();
      $display("test latency done");

      wide <= 1'b1;
      cmd(1'b1, 1'b0, 1'b0, SEL_BASE, 12'h027);
      sclr();
      cmd(1'b0, 1'b1, 1'b0, SEL_BASE, 12'h1FE);
      drain();
      check_cap("page x32", 9'h0FE, 256, 1'b0, 256);
      $display("test page x32 done");

      // Far side stalls until the buffer refuses, then drains it
      wide <= 1'b0;
      stall <= 1'b1;
      sclr();
      cmd(1'b0, 1'b1, 1'b0, SEL_BASE, 12'h1FF);
      repeat (60) @(posedge clk_in);
      #1;
      chk("stall busy", 16'({busy, col_valid}), 16'h3);
      chk("stall taken", 16'(i_sink.n_cap), 16'h0);
      @(posedge clk_in);
      stall <= 1'b0;
      drain();
      check_cap("page x16", 9'h1FF, 512, 1'b0, 512);
      $display("test stall done");

      for (int t = 0; t < 4; t++) begin
         cmd(1'b1, 1'b0, 1'b0, SEL_EXT, 12'(t << 3));
         settle();
         chk("temp range", 16'(temp), 16'(t));
      end
      cmd(1'b1, 1'b0, 1'b0, 2'h1, 12'h008);
      cmd(1'b1, 1'b0, 1'b0, 2'h3, 12'h008);
      cmd(1'b1, 1'b0, 1'b0, SEL_BASE, 12'h020);
      settle();
      chk("temp kept", 16'(temp), 16'h3);
      cmd(1'b1, 1'b0, 1'b0, SEL_EXT, 12'h020);
      settle();
      chk("ext flag", 16'({xres, temp}), 16'h4);
      cmd(1'b1, 1'b0, 1'b0, SEL_EXT, 12'h000);
      settle();
      chk("ext clear", 16'(xres), 16'h0);
      foreach (addr[i]) begin
         if (i < 4) begin
            cmd(1'b1, 1'b0, 1'b0, SEL_BASE, i == 0 ? 12'h080 : i == 1 ? 12'h070
                : i == 2 ? 12'h420 : 12'h020);
            settle();
            chk("mode flag", 16'(mres), 16'(i != 3));
         end
      end
      $display("test mode flags done");
      wrap_up();
   end
endmodule
